// File: hw/pmu_regs.vh
// Register map, field positions, event codes and reset values of the performance counter unit
// Contract
// R1: Four independent channels, each with its own event selection, counting concurrently.
// R2: Sources include disabled, elapsed time, execution states, branches, instructions, DSP instructions.
// R3: Sources include exception/interrupt, interrupt only, exception-block and privileged-mode instructions.
// R4: Sources include instruction/data conflict, other conflict, data-TLB and instruction-TLB miss cycles.
// R5: Stall cycle sources and instruction/data cache-miss occurrence counts are selectable.
// R6: Access cycle sources: other, non-cacheable, cacheable; each total, instruction, data. Other has a total code only.
// R7: Access count sources with the same classification and variants. Other again has a total code only.
// R8: Accesses uncached only by translation attribute still count as cacheable-area accesses.
// R9: With cache on, non-cacheable may undercount; cacheable and local RAM may overcount.
// R10: Branch selection adds two per taken branch.
// R11: Counters run on the processor clock and stop while it halts. Range mode ignores run_i and goes on counting.
// R12: Each channel holds a readable 32-bit counter.
// R13: Counter wrap is detected and kept readable as overflow.
// R14: Initialize request clears results; host issues it before a fresh measurement.
// R15: Under non-realtime trace, stall and execution-cycle counts are not guaranteed.
// R16: Normal mode counts from program start until any break condition.
// R17: Range mode counts between matches of the two break channels, either order.
// R18: Break channel matches used as range points do not halt the processor.
// R19: Host must not enable range mode with no channel source selected.
// R20: Sticky overflow set on wrap, cleared only by initialize; counting wraps modulo 2^32.
`ifndef PMU_REGS_VH
`define PMU_REGS_VH
// Byte offsets on the register bus
`define PMU_CTRL_OFS 8'h00
`define PMU_SEL_OFS 8'h04
`define PMU_STAT_OFS 8'h08
`define PMU_CNT0_OFS 8'h10
// Control fields
`define PMU_CTRL_INIT_BIT 0
`define PMU_CTRL_MODE_LSB 1
`define PMU_CTRL_MODE_MSB 2
`define PMU_CTRL_RST 32'h0000_0000
`define PMU_SEL_RST 32'h0000_0000
// Measurement modes
`define PMU_MODE_NORMAL 2'h0
`define PMU_MODE_R12 2'h1
`define PMU_MODE_R21 2'h2
// Event source codes, 6 bits each
`define PMU_EV_W 6
`define PMU_EV_OFF 6'h00
`define PMU_EV_TIME 6'h01
`define PMU_EV_BRANCH 6'h03
`define PMU_EV_NUM 38
`define PMU_BRANCH_STEP 32'h0000_0002
`endif

// File: hw/pmu_top.v
// Four-channel performance counter unit with a classic Wishbone register slave
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "pmu_regs.vh"
// Register map on the byte-addressed bus:
//   control at the first offset: initialize pulse in bit 0, measurement mode in bits 2:1
//   selection next: one six-bit source code per channel, one byte per channel
//   status: sticky overflow per channel, then armed and active flags
//   counters: one 32-bit word per channel, read only
// Bus timing:
//   a request is taken while ack is low and answered one cycle later
//   a write lands on the edge at which the master sees ack, read data stands with ack
//   ack lasts one cycle, so a held request is never taken twice
// Limits:
//   a window measures once per initialize; arming again needs a fresh initialize
//   counts under non-realtime tracing are only as good as the core's event timing
module pmu_top #(
  parameter NCH = 4,
  parameter NEV = `PMU_EV_NUM
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [NEV-1:0] event_i,
  input wire run_i,
  input wire brk1_i,
  input wire brk2_i,
  input wire brk_any_i,
  output reg halt_req_o,
  output reg counting_o
);

  // Control, selection, counters and window state
  reg [31:0] ctrl_r;
  reg [31:0] sel_r;
  reg [31:0] cnt_r [0:NCH-1];
  reg [NCH-1:0] ovf_r;
  reg armed_r;
  reg active_r;
  reg init_r;
  // Combinational helpers
  reg [NCH-1:0] inc_w;
  reg [31:0] step_w [0:NCH-1];
  reg [31:0] rd_nxt;
  integer i;

  wire [1:0] mode_w = ctrl_r[`PMU_CTRL_MODE_MSB:`PMU_CTRL_MODE_LSB];
  wire range_w = (mode_w == `PMU_MODE_R12) || (mode_w == `PMU_MODE_R21);
  wire req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Write lands on the edge at which ack stands, as the master sees it
  wire wr_w = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire wr_ctrl_w = wr_w && (wb_adr_i == `PMU_CTRL_OFS);
  wire wr_sel_w = wr_w && (wb_adr_i == `PMU_SEL_OFS);
  wire [31:0] stat_w = {26'h000_0000, active_r, armed_r, ovf_r};
  wire start_hit_w = (mode_w == `PMU_MODE_R12) ? brk1_i : brk2_i;
  wire stop_hit_w = (mode_w == `PMU_MODE_R12) ? brk2_i : brk1_i;

  // Highest event line index the input really has
  localparam [5:0] NEV_TOP = NEV - 1;

  // Basic sources; off, time and branch come from the shared header
  localparam [5:0] EV_STATES = 6'h02;
  localparam [5:0] EV_INSN = 6'h04;
  localparam [5:0] EV_DSP = 6'h05;
  // Conflicts, exceptions, translation misses and qualified instructions
  localparam [5:0] EV_ID_CONFLICT = 6'h06;
  localparam [5:0] EV_OTHER_CONFLICT = 6'h07;
  localparam [5:0] EV_EXC_IRQ = 6'h08;
  localparam [5:0] EV_DTLB_MISS = 6'h09;
  localparam [5:0] EV_ITLB_MISS = 6'h0a;
  localparam [5:0] EV_IRQ = 6'h0b;
  localparam [5:0] EV_EXC_BLOCK_INSN = 6'h0c;
  localparam [5:0] EV_PRIV_INSN = 6'h0d;
  // Cache misses and stall cycles
  localparam [5:0] EV_ICACHE_MISS_CNT = 6'h0e;
  localparam [5:0] EV_DCACHE_MISS_CNT = 6'h0f;
  localparam [5:0] EV_FETCH_STALL = 6'h10;
  localparam [5:0] EV_DATA_STALL = 6'h11;
  localparam [5:0] EV_ICACHE_MISS_STALL = 6'h12;
  localparam [5:0] EV_DCACHE_MISS_STALL = 6'h13;
  localparam [5:0] EV_NC_STALL = 6'h14;
  localparam [5:0] EV_XY_RAM_STALL = 6'h15;
  localparam [5:0] EV_USER_LOCAL_RAM_STALL = 6'h16;
  localparam [5:0] EV_ID_ACCESS_STALL = 6'h17;
  // Access cycles by area, total then instruction then data
  localparam [5:0] EV_OTHER_ACC_CYC = 6'h18;
  localparam [5:0] EV_NC_CYC = 6'h19;
  localparam [5:0] EV_NC_I_CYC = 6'h1a;
  localparam [5:0] EV_NC_D_CYC = 6'h1b;
  localparam [5:0] EV_C_CYC = 6'h1c;
  localparam [5:0] EV_C_I_CYC = 6'h1d;
  localparam [5:0] EV_C_D_CYC = 6'h1e;
  // Access counts by area, same split
  localparam [5:0] EV_OTHER_ACC_CNT = 6'h1f;
  localparam [5:0] EV_NC_CNT = 6'h20;
  localparam [5:0] EV_NC_I_CNT = 6'h21;
  localparam [5:0] EV_NC_D_CNT = 6'h22;
  localparam [5:0] EV_C_CNT = 6'h23;
  localparam [5:0] EV_C_I_CNT = 6'h24;
  localparam [5:0] EV_C_D_CNT = 6'h25;

  // Known source codes; an unknown code counts nothing rather than a stray line
  function ev_known;
    input [5:0] code;
    begin
      case (code)
        `PMU_EV_TIME,
        EV_STATES,
        `PMU_EV_BRANCH,
        EV_INSN,
        EV_DSP,
        EV_ID_CONFLICT,
        EV_OTHER_CONFLICT,
        EV_EXC_IRQ,
        EV_DTLB_MISS,
        EV_ITLB_MISS,
        EV_IRQ,
        EV_EXC_BLOCK_INSN,
        EV_PRIV_INSN,
        EV_ICACHE_MISS_CNT,
        EV_DCACHE_MISS_CNT,
        EV_FETCH_STALL,
        EV_DATA_STALL,
        EV_ICACHE_MISS_STALL,
        EV_DCACHE_MISS_STALL,
        EV_NC_STALL,
        EV_XY_RAM_STALL,
        EV_USER_LOCAL_RAM_STALL,
        EV_ID_ACCESS_STALL,
        EV_OTHER_ACC_CYC,
        EV_NC_CYC,
        EV_NC_I_CYC,
        EV_NC_D_CYC,
        EV_C_CYC,
        EV_C_I_CYC,
        EV_C_D_CYC,
        EV_OTHER_ACC_CNT,
        EV_NC_CNT,
        EV_NC_I_CNT,
        EV_NC_D_CNT,
        EV_C_CNT,
        EV_C_I_CNT,
        EV_C_D_CNT: begin
          ev_known = 1'b1; // see R2 R3 R4 R5 R6 R7
        end
        default: begin
          ev_known = 1'b0; // see R2
        end
      endcase
    end
  endfunction

  // Step per event; a taken branch is two valid cycles
  function [31:0] ev_step;
    input [5:0] code;
    begin
      ev_step = 32'h0000_0001;
      if (code == `PMU_EV_BRANCH) begin
        ev_step = `PMU_BRANCH_STEP; // see R10
      end
    end
  endfunction

  // Counter slot decode; channel n sits four bytes per step above the first counter
  function cnt_hit;
    input [7:0] adr;
    input integer idx;
    reg [7:0] slot;
    begin
      slot = `PMU_CNT0_OFS + {idx[5:0], 2'b00};
      cnt_hit = (adr == slot);
    end
  endfunction

  // Pick one event line by code; code 0 is the disabled setting
  function ev_pick;
    input [NEV-1:0] ev;
    input [5:0] code;
    begin
      ev_pick = 1'b0; // see R2
      if (ev_known(code) && code <= NEV_TOP) begin
        ev_pick = ev[code]; // see R3 R4 R5 R6 R7 R8 R9 R15
      end
    end
  endfunction

  // Byte-lane merge for writes
  function [31:0] lane_wr;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      lane_wr = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          lane_wr[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // Per-channel increment decision and step size
  always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
      inc_w[i] = active_r & ev_pick(event_i, sel_r[i*8 +: 6]); // see R1
      step_w[i] = ev_step(sel_r[i*8 +: 6]); // see R10
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `PMU_CTRL_OFS: rd_nxt = ctrl_r;
      `PMU_SEL_OFS: rd_nxt = sel_r;
      `PMU_STAT_OFS: rd_nxt = stat_w; // see R13
      default: begin
        for (i = 0; i < NCH; i = i + 1) begin
          if (cnt_hit(wb_adr_i, i)) begin
            rd_nxt = cnt_r[i]; // see R12
          end
        end
      end
    endcase
  end

  // Bus slave: one wait cycle, ack drops in the cycle after it was given
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_r <= `PMU_CTRL_RST;
      sel_r <= `PMU_SEL_RST;
      init_r <= 1'b0;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= rd_nxt;
      init_r <= 1'b0;
      if (wr_ctrl_w) begin
        ctrl_r <= lane_wr(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0006;
        init_r <= wb_sel_i[0] & wb_dat_i[`PMU_CTRL_INIT_BIT]; // see R14
      end
      if (wr_sel_w) begin
        sel_r <= lane_wr(sel_r, wb_dat_i, wb_sel_i) & 32'h3f3f_3f3f;
      end
    end
  end

  // Measurement window: normal runs with the program, range arms on start point
  always @(posedge clk_i) begin
    if (rst_i || init_r) begin
      armed_r <= 1'b0;
      active_r <= 1'b0;
    end else if (range_w) begin
      if (!armed_r && start_hit_w) begin
        armed_r <= 1'b1; // see R17
        active_r <= 1'b1;
      end else if (armed_r && active_r && stop_hit_w) begin
        active_r <= 1'b0; // see R17
      end
    end else begin
      if (run_i && !armed_r) begin
        armed_r <= 1'b1; // see R16
        active_r <= 1'b1;
      end else if (active_r && (brk_any_i || !run_i)) begin
        active_r <= 1'b0; // see R16
      end
    end
  end

  // Counters on the core clock; wrap is modulo 2^32 and marks sticky overflow
  // A wrap in the very cycle of an initialize still marks overflow: set wins over clear
  always @(posedge clk_i) begin
    for (i = 0; i < NCH; i = i + 1) begin
      if (rst_i) begin
        cnt_r[i] <= 32'h0000_0000;
        ovf_r[i] <= 1'b0;
      end else begin
        if (init_r) begin
          cnt_r[i] <= 32'h0000_0000; // see R14
        end else if (inc_w[i]) begin
          cnt_r[i] <= cnt_r[i] + step_w[i]; // see R11 R20
        end
        if (inc_w[i] && cnt_r[i] > (32'hffff_ffff - step_w[i])) begin
          ovf_r[i] <= 1'b1; // see R13 R20
        end else if (init_r) begin
          ovf_r[i] <= 1'b0; // see R14
        end
      end
    end
  end

  // Halt request: range points never halt the core, a real break does in normal mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      halt_req_o <= 1'b0;
      counting_o <= 1'b0;
    end else begin
      halt_req_o <= ~range_w & brk_any_i; // see R18
      counting_o <= active_r;
    end
  end

endmodule

// File: bench/pmu_chk.sv
// Port checks for the counter unit
`timescale 1ns/10ps
module pmu_chk (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] wb_adr_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire brk_any_i,
  input wire halt_req_o
);
  wire rq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = rq && !wb_we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // One-cycle answers; unused bits read as zero
  property p_ack; rq |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  property p_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_hole; rd && wb_adr_i == 8'h0C |=> wb_dat_o == 32'h0000_0000; endproperty
  a_hole: assert property (p_hole) else $error("hole data");
  property p_init; rd && wb_adr_i == 8'h00 |=> !wb_dat_o[0]; endproperty
  a_init: assert property (p_init) else $error("init sticks");
  property p_stat; rd && wb_adr_i == 8'h08 |=> wb_dat_o[31:6] == 26'h000_0000; endproperty
  a_stat: assert property (p_stat) else $error("status pad");
  property p_sel; rd && wb_adr_i == 8'h04 |=> (wb_dat_o & 32'hC0C0_C0C0) == 32'h0; endproperty
  a_sel: assert property (p_sel) else $error("select pad");
  // Halt only ever follows a break one cycle earlier
  property p_halt; !brk_any_i |=> !halt_req_o; endproperty
  a_halt: assert property (p_halt) else $error("stray halt");
endmodule

// File: bench/pmu_core_mdl.sv
// Core event source model
`timescale 1ns/10ps
module pmu_core_mdl (
  input wire clk_i,
  input wire en_i,
  output logic [37:0] event_o = 0,
  output logic [31:0] n_o = 0
);
  // Every line pulses each other cycle; lines idle low, as a quiet core shows
  always @(posedge clk_i) begin
    event_o <= en_i ? ~event_o : 38'h0;
    n_o <= n_o + {31'h0, event_o[1]};
  end
endmodule

// File: bench/tb_cpu_performance_counters.sv
// Bench for the counter unit
`timescale 1ns/10ps
`include "pmu_regs.vh"
module tb_cpu_performance_counters;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, run_i = 0, brk_any_i = 0, en = 0;
  logic brk1_i = 0, brk2_i = 0;
  logic wb_ack_o, halt_req_o, counting_o;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, n, c;
  logic [37:0] event_i;
  int checks = 0, miscompares = 0, i;
  always #25 clk_i = ~clk_i;
  pmu_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_i(event_i), .run_i(run_i), .brk1_i(brk1_i), .brk2_i(brk2_i), .brk_any_i(brk_any_i),
    .halt_req_o(halt_req_o), .counting_o(counting_o));
  pmu_core_mdl u_core (.clk_i(clk_i), .en_i(en), .event_o(event_i), .n_o(n));
  task chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Classic cycle held until ack; a read is compared with e
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d, e);
    @(posedge clk_i);
    {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'b11};
    i = 0;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && i++ < 20);
    chk(wb_ack_o, 1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (!w) chk(wb_dat_o, e);
  endtask
  task t_regs;
    wb(`PMU_CTRL_OFS, 0, 0, `PMU_CTRL_RST);
    wb(8'h0C, 0, 0, 0);
    wb(`PMU_STAT_OFS, 1, 32'hFFFF_FFFF, 0);
    wb(`PMU_STAT_OFS, 0, 0, 0);
    wb(`PMU_SEL_OFS, 1, 32'h0024_0503, 0);
    wb(`PMU_SEL_OFS, 0, 0, 32'h0024_0503);
  endtask
  // Four channels at once: branch, two plain sources, one disabled
  task t_count;
    wb(`PMU_CTRL_OFS, 1, 1, 0);
    run_i <= 1;
    repeat (4) @(posedge clk_i);
    en <= 1;
    repeat (20) @(posedge clk_i);
    en <= 0;
    repeat (4) @(posedge clk_i);
    chk(counting_o, 1);
    wb(`PMU_CNT0_OFS, 0, 0, n * 2);
    wb(`PMU_CNT0_OFS + 8'h04, 0, 0, n);
    wb(`PMU_CNT0_OFS + 8'h08, 0, 0, n);
    wb(`PMU_CNT0_OFS + 8'h0C, 0, 0, 0);
  endtask
  // A break closes the window; later events must not count
  task t_brk;
    c = n;
    brk_any_i <= 1;
    @(posedge clk_i);
    brk_any_i <= 0;
    @(posedge clk_i);
    chk(halt_req_o, 1);
    en <= 1;
    repeat (10) @(posedge clk_i);
    en <= 0;
    chk(counting_o, 0);
    wb(`PMU_CNT0_OFS + 8'h04, 0, 0, c);
    wb(`PMU_CTRL_OFS, 1, 1, 0);
    run_i <= 0;
    wb(`PMU_CNT0_OFS, 0, 0, 0);
  endtask
  // Range window from one break channel to the other; the start match must not halt the core
  task t_range(input logic [31:0] m, input logic s2);
    wb(`PMU_CTRL_OFS, 1, m, 0);
    repeat (2) @(posedge clk_i);
    {brk1_i, brk2_i, brk_any_i} <= {~s2, s2, 1'b1};
    @(posedge clk_i);
    {brk1_i, brk2_i, brk_any_i} <= 3'b000;
    @(posedge clk_i);
    chk(halt_req_o, 0);
    c = n;
    en <= 1;
    repeat (10) @(posedge clk_i);
    en <= 0;
    repeat (2) @(posedge clk_i);
    chk(counting_o, 1);
    c = n - c;
    {brk1_i, brk2_i} <= {s2, ~s2};
    @(posedge clk_i);
    {brk1_i, brk2_i} <= 2'b00;
    en <= 1;
    repeat (10) @(posedge clk_i);
    en <= 0;
    repeat (2) @(posedge clk_i);
    chk(counting_o, 0);
    wb(`PMU_CNT0_OFS + 8'h04, 0, 0, c);
    wb(`PMU_CNT0_OFS, 0, 0, c * 2);
  endtask
  task test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    t_regs;
    t_count;
    t_brk;
    t_range(32'h0000_0003, 1'b0);
    t_range(32'h0000_0005, 1'b1);
    test_done;
  end
  // Run needs under two hundred cycles; over twenty-five times that means a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    test_done;
  end
endmodule
bind pmu_top pmu_chk u_chk (.*);
